// file: dv/aic_cop_model.sv
// coprocessor model that answers after a set number of cycles
`timescale 1ns/1ps
module aic_cop_model
	import aic_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic nrst_i, // sync reset, active low
	input wire logic valid_i, // instruction pulse
	input wire logic [31:0] instr_i, // instruction word
	input wire logic abort_i, // abort pulse
	input wire logic [3:0] lat_i, // cycles to done, at least 1
	output logic done_o, // done pulse
	output logic bad_o // own decode found no usable space
);
	logic [3:0] cnt_reg;
	logic [5:0] op_reg;

	always_ff @(posedge clk_i) begin
		if (!nrst_i || abort_i) begin
			cnt_reg <= 4'h0;
		end else if (valid_i) begin
			cnt_reg <= lat_i;
			op_reg <= instr_i[31:26];
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	// one-cycle done, so a reissue never sees a stale one
	assign done_o = (cnt_reg == 4'h1);
	// own decode of the last word received
	assign bad_o = !(op_reg inside {PRI_CUSTOM, PRI_MIXED, PRI_FP_SINGLE, PRI_FP_DOUBLE});
endmodule : aic_cop_model

// file: dv/aic_ctrl_monitor.sv
// assertion checker on the classifier ports
`timescale 1ns/1ps
module aic_ctrl_monitor (
	input wire logic CLK_I, // clock
	input wire logic NRST_I, // reset
	input wire logic ISSUE_VALID_I, // offer
	input wire logic ISSUE_READY_O, // take
	input wire logic STALL_O, // stall
	input wire logic IRQ_HOLD_O, // hold
	input wire logic IRQ_PEND_I, // irq
	input wire logic UNRECOG_O, // unusable
	input wire logic RES_VALID_O, // report
	input wire logic CP_VALID_O, // issue
	input wire logic CP_DONE_I, // done in
	input wire logic CP_ABORT_O, // abort
	input wire logic ABORTED_O, // aborted
	input wire logic DONE_O, // done out
	input wire logic AUX_READY_O // usable
);
	// one clock domain, quiet during reset
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	chk_take_answer: assert property (
		ISSUE_VALID_I && ISSUE_READY_O ##1 1'b1 |-> (CP_VALID_O && RES_VALID_O) != UNRECOG_O)
		else $error("take not answered once");
	chk_ready_unit: assert property (
		!AUX_READY_O |-> !ISSUE_READY_O ##1 (!CP_VALID_O && !UNRECOG_O))
		else $error("ready without unit");
	chk_busy_refuse: assert property (CP_VALID_O |-> !ISSUE_READY_O)
		else $error("ready while busy");
	chk_done_release: assert property (STALL_O && CP_DONE_I |=> DONE_O && !STALL_O)
		else $error("done not released");
	chk_stall_keep: assert property (
		STALL_O && !CP_DONE_I && !IRQ_PEND_I |=> STALL_O && !DONE_O)
		else $error("stall dropped early");
	chk_hold_keep: assert property (
		IRQ_HOLD_O && !CP_DONE_I |=> IRQ_HOLD_O && !CP_ABORT_O)
		else $error("blocking instruction lost");
	chk_abort_cause: assert property (
		CP_ABORT_O |-> ABORTED_O && !STALL_O && $past(IRQ_PEND_I) && !$past(CP_DONE_I))
		else $error("abort without cause");
	chk_auto_free: assert property (CP_VALID_O && !STALL_O |=> !STALL_O && !DONE_O)
		else $error("autonomous stalled");

	cov_abort: cover property (CP_ABORT_O);
	cov_hold: cover property (IRQ_HOLD_O && IRQ_PEND_I);
	cov_unrecog: cover property (UNRECOG_O);
	cov_auto: cover property (CP_VALID_O && !STALL_O);
endmodule : aic_ctrl_monitor

bind aic_ctrl aic_ctrl_monitor mon_u (
	.CLK_I, .NRST_I, .ISSUE_VALID_I, .ISSUE_READY_O, .STALL_O, .IRQ_HOLD_O, .IRQ_PEND_I,
	.UNRECOG_O, .RES_VALID_O, .CP_VALID_O, .CP_DONE_I, .CP_ABORT_O, .ABORTED_O, .DONE_O,
	.AUX_READY_O
);

// file: dv/tb_top.sv
// self-checking bench for the auxiliary instruction classifier
`timescale 1ns/1ps
module tb_top
	import aic_pkg::*;
;
	logic clk, nrst, mwr, c_auto, c_blk, c_imm, f_blk, vld, irq, cpe, cpf;
	logic [31:0] mdat, ins, cpi;
	logic rdy, stall, hold, unrec, rv, sa, sb, tg, scnd, done, abrt, cpv, cpa, cpd;
	logic axe, fpe, fpp, axr, fpu, bad;
	logic [3:0] lat;
	aic_fpx_type fpm;
	int err_count, checks;

	// classifier and its coprocessor
	aic_ctrl dut_u (
		.CLK_I(clk), .NRST_I(nrst), .MSW_WR_I(mwr), .MSW_DATA_I(mdat),
		.CUST_AUTO_I(c_auto), .CUST_BLOCK_I(c_blk), .CUST_IMM_I(c_imm), .FPU_BLOCK_I(f_blk),
		.ISSUE_VALID_I(vld), .ISSUE_INSTR_I(ins), .ISSUE_READY_O(rdy), .STALL_O(stall),
		.IRQ_HOLD_O(hold), .IRQ_PEND_I(irq), .UNRECOG_O(unrec), .RES_VALID_O(rv),
		.RES_SRC_A_O(sa), .RES_SRC_B_O(sb), .RES_TGT_O(tg), .RES_SETS_COND_O(scnd),
		.DONE_O(done), .ABORTED_O(abrt), .CP_VALID_O(cpv), .CP_INSTR_O(cpi),
		.CP_ABORT_O(cpa), .CP_DONE_I(cpd), .CP_EXC_I(cpe), .CP_FP_EXC_I(cpf),
		.AUX_EXC_O(axe), .FP_EXC_O(fpe), .FP_EXC_PRECISE_O(fpp), .AUX_READY_O(axr),
		.FPU_PRESENT_O(fpu), .FP_MODE_O(fpm)
	);
	aic_cop_model cop_u (
		.clk_i(clk), .nrst_i(nrst), .valid_i(cpv), .instr_i(cpi), .abort_i(cpa),
		.lat_i(lat), .done_o(cpd), .bad_o(bad)
	);

	task automatic stop_test();
		if (err_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input bit ok, input string msg);
		checks++;
		if (!ok) begin
			err_count++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask : chk

	function automatic logic [31:0] mk(input logic [5:0] p, input logic [9:0] e);
		return {p, 15'h0000, e, 1'b0};
	endfunction : mk

	task automatic msw(input logic [31:0] d);
		@(negedge clk) mwr = 1'b1;
		mdat = d;
		@(negedge clk) mwr = 1'b0;
	endtask : msw

	// ready is polled at falling edges, so the take edge is never raced
	task automatic issue(input logic [31:0] w, input bit good);
		int n;
		n = 0;
		@(negedge clk) vld = 1'b1;
		ins = w;
		while (rdy !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk);
		end
		@(negedge clk) vld = 1'b0;
		chk(n < 50 && unrec === !good && cpv === good && rv === good, "issue answer");
		chk(!good || cpi === w, "forwarded word");
	endtask : issue

	task automatic wait_hi(input bit r);
		int n;
		n = 0;
		while ((r ? rdy : done) !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk);
		end
		chk(n < 50, "no completion");
	endtask : wait_hi

	task automatic t_config();
		logic [31:0] w;
		w = (32'h1 << MSW_AUX_POS) | (32'h1 << MSW_FPU_POS) | (32'h1 << MSW_EXC_POS);
		chk(axr === 1'b0 && rdy === 1'b0, "ready out of reset");
		msw(32'h0);
		chk(rdy === 1'b0, "ready without unit");
		msw(32'h1 << MSW_AUX_POS);
		chk(rdy === 1'b1 && fpu === 1'b0, "unit bits");
		issue(mk(PRI_FP_SINGLE, 10'h000), 1'b0);
		for (int m = 0; m < 4; m++) begin
			msw(w | (32'(m & 1) << MSW_FE_A_POS) | (32'(m >> 1) << MSW_FE_B_POS));
			chk(fpm === 2'(m) && fpu === 1'b1, "mode");
		end
	endtask : t_config

	task automatic t_decode();
		logic [31:0] op [8];
		bit good [8] = '{0, 1, 0, 1, 1, 1, 1, 0};
		bit cnd [8] = '{0, 0, 0, 1, 0, 0, 0, 0};
		op = '{mk(PRI_CUSTOM, EXT_ILLEGAL), mk(PRI_CUSTOM, 10'h3ff), mk(PRI_MIXED, 10'h004),
			mk(PRI_MIXED, 10'h046), mk(PRI_MIXED, 10'h001), mk(PRI_FP_SINGLE, 10'h000),
			mk(PRI_FP_DOUBLE, 10'h3ff), mk(6'h1f, 10'h00e)};
		foreach (op[i]) begin
			issue(op[i], good[i]);
			if (good[i]) begin
				chk(stall === 1'b1 && {sa, sb, tg} === 3'h7, "resources");
				chk(scnd === cnd[i], "condition flag");
				wait_hi(1'b0);
				chk(stall === 1'b0 && rdy === 1'b1, "release");
				chk(bad === 1'b0, "coprocessor decode");
			end
		end
	endtask : t_decode

	task automatic t_auto();
		c_auto = 1'b1;
		issue(mk(PRI_CUSTOM, 10'h001), 1'b1);
		chk(stall === 1'b0 && tg === 1'b0 && rdy === 1'b0, "autonomous");
		wait_hi(1'b1);
		chk(done === 1'b0, "autonomous done");
		c_auto = 1'b0;
		c_imm = 1'b1;
		issue(mk(PRI_CUSTOM, 10'h002), 1'b1);
		chk({sa, sb, tg} === 3'h0, "immediate fields");
		wait_hi(1'b0);
		c_imm = 1'b0;
	endtask : t_auto

	task automatic t_irq();
		// pass 2 blocks through the floating setting, pass 1 through the custom one
		for (int b = 2; b >= 0; b--) begin
			c_blk = (b == 1);
			f_blk = (b == 2);
			issue(b == 2 ? mk(PRI_FP_SINGLE, 10'h000) : mk(PRI_CUSTOM, 10'h001), 1'b1);
			irq = 1'b1;
			chk(hold === 1'b0, "early hold");
			@(negedge clk);
			irq = 1'b0;
			chk(hold === (b != 0) && abrt === (b == 0) && cpa === (b == 0), "interrupt");
			if (b == 0) issue(mk(PRI_CUSTOM, 10'h001), 1'b1);
			wait_hi(1'b0);
		end
	endtask : t_irq

	task automatic t_exc();
		logic [31:0] base;
		logic [31:0] wd [4];
		logic [2:0] xp [4];
		base = (32'h1 << MSW_AUX_POS) | (32'h1 << MSW_EXC_POS) | (32'h1 << MSW_FPU_POS);
		wd = '{32'h1 << MSW_AUX_POS, 32'hffff_ffff, base, base | (32'h1 << MSW_FE_A_POS)};
		// expected {aux exception, floating exception, precise}
		xp = '{3'h0, 3'h7, 3'h4, 3'h6};
		for (int e = 0; e < 4; e++) begin
			msw(wd[e]);
			{cpe, cpf} = 2'h3;
			@(negedge clk);
			{cpe, cpf} = 2'h0;
			chk({axe, fpe, fpp} === xp[e], "exception gate");
		end
	endtask : t_exc

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// watchdog well beyond the roughly 120 cycles the scenarios take
	initial begin
		#100000;
		err_count++;
		stop_test();
	end

	// reset, then the scenarios in order
	initial begin
		{nrst, mwr, c_auto, c_blk, c_imm, f_blk, vld, irq, cpe, cpf} = 10'h000;
		mdat = 32'h0;
		ins = 32'h0;
		lat = 4'h3;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		t_config();
		t_decode();
		t_auto();
		lat = 4'h6;
		t_irq();
		t_exc();
		stop_test();
	end
endmodule : tb_top

// file: rtl/aic_ctrl.sv
// issue control and classification of co-processor instructions
//
// Summary of operation
// - no instruction accepted until software has written the machine state word
// - state bit 6 set means auxiliary unit present, else path unusable
// - state bit 12 gates exceptions coming from the auxiliary unit
// - state bit 18 set means a floating point co-processor is present
// - bits 20 and 23 pick ignore, imprecise or precise floating exception mode
// - on local decode, report source and target resource needs to the processor
// - autonomous instructions never stall the pipeline and return nothing
// - next instruction waits while co-processor is still busy with an earlier one
// - non-autonomous instruction stalls the pipeline until co-processor done
// - instructions that cannot be reissued safely are configured blocking
// - blocking instruction holds off interrupts after its first execute cycle
// - non-blocking instruction may be aborted for interrupts and later reissued
// - predefined instructions use source and target fields as registers
// - custom instructions may treat their fields as immediates
// - primary 0 extended zero is illegal; rest are custom without condition update
// - primary 4: low 10- reserved, 1000110 custom with condition, rest custom
// - primaries 59 and 63 are floating point arithmetic for the co-processor
`timescale 1ns/1ps
module aic_ctrl
	import aic_pkg::*;
#(
	parameter int INSTR_W = 32 // instruction width, only 32 served
)
(
	input wire logic CLK_I, // 40 MHz clock
	input wire logic NRST_I, // synchronous reset, active low
	input wire logic MSW_WR_I, // machine_state_word write strobe
	input wire logic [31:0] MSW_DATA_I, // machine_state_word write data
	input wire logic CUST_AUTO_I, // custom instructions are autonomous
	input wire logic CUST_BLOCK_I, // custom non-autonomous are blocking
	input wire logic CUST_IMM_I, // custom fields are immediates
	input wire logic FPU_BLOCK_I, // floating instructions are blocking
	input wire logic ISSUE_VALID_I, // processor offers an instruction
	input wire logic [INSTR_W-1:0] ISSUE_INSTR_I, // offered instruction
	output logic ISSUE_READY_O, // instruction may be taken
	output logic STALL_O, // processor pipeline stalled
	output logic IRQ_HOLD_O, // interrupts and exceptions held off
	input wire logic IRQ_PEND_I, // processor wants to take an interrupt
	output logic UNRECOG_O, // unrecognised instruction pulse
	output logic RES_VALID_O, // resource report pulse
	output logic RES_SRC_A_O, // needs first_source_field register
	output logic RES_SRC_B_O, // needs second_source_field register
	output logic RES_TGT_O, // writes target_field register
	output logic RES_SETS_COND_O, // may update condition_register
	output logic DONE_O, // non-autonomous instruction finished
	output logic ABORTED_O, // non-blocking instruction aborted
	output logic CP_VALID_O, // instruction pulse to coprocessor
	output logic [INSTR_W-1:0] CP_INSTR_O, // instruction to coprocessor
	output logic CP_ABORT_O, // abort pulse to coprocessor
	input wire logic CP_DONE_I, // coprocessor finished current one
	input wire logic CP_EXC_I, // coprocessor raises an exception
	input wire logic CP_FP_EXC_I, // coprocessor floating exception
	output logic AUX_EXC_O, // gated coprocessor exception pulse
	output logic FP_EXC_O, // floating exception pulse
	output logic FP_EXC_PRECISE_O, // floating exception is precise
	output logic AUX_READY_O, // auxiliary unit usable
	output logic FPU_PRESENT_O, // floating co-processor present
	output aic_fpx_type FP_MODE_O // floating exception mode
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// the field slices in the package assume a 32-bit word
	if (INSTR_W != 32) begin : g_width_check
		$error("aic_ctrl serves only 32-bit instructions");
	end

	////////////////////////////////////////////////////////////////////////////
	// machine state word

	logic [31:0] msw_reg;
	logic configured_reg;
	logic aux_ok;
	logic exc_en;
	logic fpu_ok;
	aic_fpx_type fp_mode;

	// register written only by software
	// a write while busy acts at once, so the unit may turn unready mid-instruction
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			msw_reg <= MSW_RESET;
		end else if (MSW_WR_I) begin
			msw_reg <= MSW_DATA_I;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			configured_reg <= 1'b0;
		end else if (MSW_WR_I) begin
			configured_reg <= 1'b1;
		end
	end

	assign aux_ok = configured_reg && msw_reg[MSW_AUX_POS];
	assign exc_en = msw_reg[MSW_EXC_POS];
	assign fpu_ok = msw_reg[MSW_FPU_POS];
	// two-bit mode from bits 20 and 23
	assign fp_mode = aic_fpx_type'({msw_reg[MSW_FE_B_POS], msw_reg[MSW_FE_A_POS]});

	////////////////////////////////////////////////////////////////////////////
	// decode
	// pure logic; its result is only used in the cycle of the take

	aic_space_type space;
	logic dec_src_a;
	logic dec_src_b;
	logic dec_tgt;
	logic usable;
	logic is_auto;
	logic is_block;

	aic_decode u_decode (
		.instr_i(ISSUE_INSTR_I),
		.fpu_ok_i(fpu_ok),
		.cust_imm_i(CUST_IMM_I),
		.space_o(space),
		.src_a_o(dec_src_a),
		.src_b_o(dec_src_b),
		.tgt_o(dec_tgt)
	);

	// only custom and floating spaces are usable
	assign usable = (space == SPC_CUST) || (space == SPC_CUST_COND) || (space == SPC_FPU);

	// floating ops without a target return nothing, so they run autonomous
	assign is_auto = (space == SPC_FPU) ? !dec_tgt : CUST_AUTO_I;
	assign is_block = (space == SPC_FPU) ? FPU_BLOCK_I : CUST_BLOCK_I;

	////////////////////////////////////////////////////////////////////////////
	// issue sequencer

	aic_state_type state_reg;
	aic_state_type state_next;
	logic block_reg;
	logic take;

	// unusable words never leave idle, so they may follow back to back
	// nothing new while the coprocessor is busy
	assign ISSUE_READY_O = aux_ok && (state_reg == ST_IDLE);
	assign take = ISSUE_VALID_I && ISSUE_READY_O;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (take && usable) begin
					state_next = is_auto ? ST_AUTO_BUSY : ST_FIRST_EX;
				end
			end
			ST_AUTO_BUSY: begin
				if (CP_DONE_I) begin
					state_next = ST_IDLE;
				end
			end
			// a blocking instruction still lets an interrupt in during this cycle;
			// the hold only starts once its first execute cycle is over
			ST_FIRST_EX: begin
				if (CP_DONE_I) begin
					state_next = ST_IDLE;
				end else if (IRQ_PEND_I && !block_reg) begin
					state_next = ST_IDLE;
				end else begin
					state_next = ST_WAIT_DONE;
				end
			end
			ST_WAIT_DONE: begin
				if (CP_DONE_I) begin
					state_next = ST_IDLE;
				end else if (IRQ_PEND_I && !block_reg) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// class of the instruction in flight
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			block_reg <= 1'b0;
		end else if (take && usable) begin
			block_reg <= is_block && !is_auto;
		end
	end

	assign STALL_O = (state_reg == ST_FIRST_EX) || (state_reg == ST_WAIT_DONE);
	assign IRQ_HOLD_O = block_reg && (state_reg == ST_WAIT_DONE);

	////////////////////////////////////////////////////////////////////////////
	// processor-side reports

	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			RES_VALID_O <= 1'b0;
			RES_SRC_A_O <= 1'b0;
			RES_SRC_B_O <= 1'b0;
			RES_TGT_O <= 1'b0;
			RES_SETS_COND_O <= 1'b0;
		end else begin
			RES_VALID_O <= take && usable;
			if (take && usable) begin
				RES_SRC_A_O <= dec_src_a;
				RES_SRC_B_O <= dec_src_b;
				RES_TGT_O <= dec_tgt && !is_auto;
				RES_SETS_COND_O <= (space == SPC_CUST_COND);
			end
		end
	end

	// illegal, reserved or unknown spaces bounce back
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			UNRECOG_O <= 1'b0;
		end else begin
			UNRECOG_O <= take && !usable;
		end
	end

	// completion and abort pulses toward the processor
	// done wins when it meets an interrupt in the same cycle
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			DONE_O <= 1'b0;
			ABORTED_O <= 1'b0;
		end else begin
			DONE_O <= STALL_O && CP_DONE_I;
			ABORTED_O <= STALL_O && !CP_DONE_I && IRQ_PEND_I && !block_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// coprocessor side

	// the word is held after the pulse, so a slow coprocessor may sample it late
	// whole word forwarded; coprocessor decodes it again
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			CP_VALID_O <= 1'b0;
			CP_INSTR_O <= '0;
			CP_ABORT_O <= 1'b0;
		end else begin
			CP_VALID_O <= take && usable;
			if (take && usable) begin
				CP_INSTR_O <= ISSUE_INSTR_I;
			end
			CP_ABORT_O <= STALL_O && !CP_DONE_I && IRQ_PEND_I && !block_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// exceptions

	// the precise flag is a level that follows the mode one cycle late
	// aux ones gated by enable; ignore mode drops floating ones
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			AUX_EXC_O <= 1'b0;
			FP_EXC_O <= 1'b0;
			FP_EXC_PRECISE_O <= 1'b0;
		end else begin
			AUX_EXC_O <= CP_EXC_I && exc_en && aux_ok;
			FP_EXC_O <= CP_FP_EXC_I && fpu_ok && (fp_mode != FPX_IGNORE);
			FP_EXC_PRECISE_O <= (fp_mode == FPX_PRECISE);
		end
	end

	// status views of the state word
	assign AUX_READY_O = aux_ok;
	assign FPU_PRESENT_O = fpu_ok;
	assign FP_MODE_O = fp_mode;

endmodule : aic_ctrl

// file: rtl/aic_decode.sv
// combinational opcode-space and resource decode of one instruction
`timescale 1ns/1ps
module aic_decode
	import aic_pkg::*;
(
	input wire logic [31:0] instr_i, // instruction word
	input wire logic fpu_ok_i, // floating unit present
	input wire logic cust_imm_i, // custom fields are immediates
	output aic_space_type space_o, // opcode space
	output logic src_a_o, // needs first_source_field register
	output logic src_b_o, // needs second_source_field register
	output logic tgt_o // writes target_field register
);

	// opcode space lookup for the custom, mixed and floating primaries
	function automatic aic_space_type classify(input logic [5:0] pri, input logic [9:0] ext,
			input logic fpu_ok);
		aic_space_type s;
		s = SPC_NONE;
		if (pri == PRI_CUSTOM) begin
			s = (ext == EXT_ILLEGAL) ? SPC_ILLEGAL : SPC_CUST;
		end else if (pri == PRI_MIXED) begin
			if (ext[EXT_MAC_HI:EXT_MAC_LO] == EXT_MAC_TOP) begin
				s = SPC_MAC_RSVD;
			end else if (ext[EXT_COND_HI:EXT_COND_LO] == EXT_CUST_COND) begin
				s = SPC_CUST_COND;
			end else begin
				s = SPC_CUST;
			end
		end else if ((pri == PRI_FP_SINGLE) || (pri == PRI_FP_DOUBLE)) begin
			// without a floating unit the space is simply not there
			s = fpu_ok ? SPC_FPU : SPC_NONE;
		end
		return s;
	endfunction : classify

	always_comb begin
		space_o = classify(instr_i[PRI_HI:PRI_LO], instr_i[EXT_HI:EXT_LO], fpu_ok_i);
		src_a_o = 1'b0;
		src_b_o = 1'b0;
		tgt_o = 1'b0;
		if (space_o == SPC_FPU) begin
			src_a_o = 1'b1;
			src_b_o = 1'b1;
			tgt_o = 1'b1;
		end else if ((space_o == SPC_CUST) || (space_o == SPC_CUST_COND)) begin
			src_a_o = !cust_imm_i;
			src_b_o = !cust_imm_i;
			tgt_o = !cust_imm_i;
		end
	end

endmodule : aic_decode

// file: rtl/aic_pkg.sv
// shared constants and types of the auxiliary instruction classifier
package aic_pkg;

	// machine_state_word bit positions; printed numbering is msb-first
	localparam int MSW_W = 32;
	localparam int MSW_AUX_POS = MSW_W - 1 - 6;
	localparam int MSW_EXC_POS = MSW_W - 1 - 12;
	localparam int MSW_FPU_POS = MSW_W - 1 - 18;
	localparam int MSW_FE_A_POS = MSW_W - 1 - 20;
	localparam int MSW_FE_B_POS = MSW_W - 1 - 23;
	localparam logic [31:0] MSW_RESET = 32'h0000_0000;

	// instruction fields, little-endian slices of the 32-bit word
	localparam int PRI_HI = 31;
	localparam int PRI_LO = 26;
	localparam int TGT_HI = 25;
	localparam int TGT_LO = 21;
	localparam int SRCA_HI = 20;
	localparam int SRCA_LO = 16;
	localparam int SRCB_HI = 15;
	localparam int SRCB_LO = 11;
	localparam int EXT_HI = 10;
	localparam int EXT_LO = 1;

	// opcode constants
	localparam logic [5:0] PRI_CUSTOM = 6'h00;
	localparam logic [5:0] PRI_MIXED = 6'h04;
	localparam logic [5:0] PRI_FP_SINGLE = 6'h3b;
	localparam logic [5:0] PRI_FP_DOUBLE = 6'h3f;
	localparam logic [9:0] EXT_ILLEGAL = 10'h000;
	localparam logic [1:0] EXT_MAC_TOP = 2'h2;
	localparam int EXT_MAC_HI = 2;
	localparam int EXT_MAC_LO = 1;
	localparam logic [6:0] EXT_CUST_COND = 7'h46;
	localparam int EXT_COND_HI = 6;
	localparam int EXT_COND_LO = 0;

	// opcode space of one instruction
	typedef enum logic [2:0] {
		SPC_NONE = 3'b000,
		SPC_ILLEGAL = 3'b001,
		SPC_CUST = 3'b010,
		SPC_CUST_COND = 3'b011,
		SPC_MAC_RSVD = 3'b100,
		SPC_FPU = 3'b101
	} aic_space_type;

	// floating exception mode, bits are {mode_b, mode_a}
	typedef enum logic [1:0] {
		FPX_IGNORE = 2'b00,
		FPX_IMP_REC = 2'b01,
		FPX_IMP_NONREC = 2'b10,
		FPX_PRECISE = 2'b11
	} aic_fpx_type;

	// issue sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_AUTO_BUSY = 2'b01,
		ST_FIRST_EX = 2'b10,
		ST_WAIT_DONE = 2'b11
	} aic_state_type;

endpackage : aic_pkg
